// ==== core/qpdbi_consts.svh ====
// constants for the quad-pumped inverted data bus: widths, field positions,
// idle levels and timing counts; included by the interface, the lane, both end modules and the bench
`ifndef QPDBI_CONSTS_SVH
`define QPDBI_CONSTS_SVH

// ====================================================================
// widths and field positions
`define QPDBI_DATA_W 64
`define QPDBI_GROUP_W 16
`define QPDBI_NUM_GROUPS 4
`define QPDBI_BEATS 4
`define QPDBI_LINE_W 256
`define QPDBI_BEAT_SHIFT 6
`define QPDBI_GROUP_SHIFT 4

// ====================================================================
// idle levels (lines are asserted low and pulled high when released)
`define QPDBI_DATA_IDLE 64'hFFFF_FFFF_FFFF_FFFF
`define QPDBI_FLAGS_IDLE 4'hF

// ====================================================================
// timing counts: beat numbers, and the link clock period in ns
`define QPDBI_BEAT_FIRST 2'h0
`define QPDBI_BEAT_LAST 2'h3
`define QPDBI_LINK_PERIOD_NS 125

`endif

// ==== core/qpdbi_pkg.sv ====
// types shared by both ends of the quad-pumped data bus
// assumes qpdbi_consts.svh is on the include path
package qpdbi_pkg;

  // ====================================================================
  // driver state, gray coded along idle -> drive -> tail
  typedef enum logic [1:0] {
    qpdbi_idle = 2'h0,
    qpdbi_drive = 2'h1,
    qpdbi_tail = 2'h3
  } qpdbi_state_type;

endpackage

// ==== core/qpdbi_bus_if.sv ====
// pin-level meeting point of the processor end and the far agent end
// assumes the bench joins both modports; released lines are pulled high here
`timescale 1ns/1ns
`include "qpdbi_consts.svh"
interface qpdbi_bus_if;
  // ====================================================================
  // resolved wires seen by both ends
  logic [63:0] data_n;
  logic data_valid_flag_n;
  logic [3:0] positive_data_strobes_n;
  logic [3:0] negative_data_strobes_n;
  logic [3:0] group_inversion_flags_n;

  // ====================================================================
  // per-end drive values and enables
  logic [63:0] cpu_data_o;
  logic cpu_valid_o;
  logic [3:0] cpu_pos_o;
  logic [3:0] cpu_neg_o;
  logic [3:0] cpu_inv_o;
  logic cpu_oe;
  logic [63:0] agt_data_o;
  logic agt_valid_o;
  logic [3:0] agt_pos_o;
  logic [3:0] agt_neg_o;
  logic [3:0] agt_inv_o;
  logic agt_oe;

  // wire resolution; an undriven line floats to its pull-up level
  assign data_n = cpu_oe ? cpu_data_o : (agt_oe ? agt_data_o : `QPDBI_DATA_IDLE);
  assign data_valid_flag_n = cpu_oe ? cpu_valid_o : (agt_oe ? agt_valid_o : 1'b1);
  assign positive_data_strobes_n = cpu_oe ? cpu_pos_o :
    (agt_oe ? agt_pos_o : `QPDBI_FLAGS_IDLE);
  assign negative_data_strobes_n = cpu_oe ? cpu_neg_o :
    (agt_oe ? agt_neg_o : `QPDBI_FLAGS_IDLE);
  assign group_inversion_flags_n = cpu_oe ? cpu_inv_o :
    (agt_oe ? agt_inv_o : `QPDBI_FLAGS_IDLE);

  modport cpu_end (
    input data_n, data_valid_flag_n, positive_data_strobes_n,
    input negative_data_strobes_n, group_inversion_flags_n,
    output cpu_data_o, cpu_valid_o, cpu_pos_o, cpu_neg_o, cpu_inv_o, cpu_oe
  );

  modport agent_end (
    input data_n, data_valid_flag_n, positive_data_strobes_n,
    input negative_data_strobes_n, group_inversion_flags_n,
    output agt_data_o, agt_valid_o, agt_pos_o, agt_neg_o, agt_inv_o, agt_oe
  );
endinterface

// ==== core/qpdbi_lane.sv ====
// one 16-line data group: inversion coding and strobes on the way out,
// strobe-edge capture and decoding on the way in
// assumes all inputs are on link_clk; pin inputs arrive unsynchronised
`timescale 1ns/1ns
`include "qpdbi_consts.svh"
module qpdbi_lane #(
  parameter int W = `QPDBI_GROUP_W
) (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic beat_valid,
  input wire logic [1:0] beat_idx,
  input wire logic [W-1:0] tx_group,
  input wire logic listen,
  input wire logic valid_sync_n,
  input wire logic [W-1:0] data_pin,
  input wire logic pos_pin,
  input wire logic neg_pin,
  input wire logic inv_pin,
  output logic [W-1:0] data_out,
  output logic pos_out,
  output logic neg_out,
  output logic inv_out,
  output logic [4*W-1:0] rx_words,
  output logic rx_done
);
  // ====================================================================
  // transmit coding
  logic [W-1:0] prev;

  function automatic logic [7:0] count_ones(input logic [W-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < W; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  // asserted-low lines: a true one is sent as a low level
  wire [W-1:0] plain_wire = ~tx_group;
  wire [W-1:0] flips = plain_wire ^ prev;
  wire use_inv = count_ones(flips) > 8'(W / 2); // R7
  wire [W-1:0] next_wire = use_inv ? tx_group : plain_wire; // R6

  // pins are registered; prev follows the bus, idle counts as all high
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= {W{1'b1}};
      data_out <= {W{1'b1}};
      inv_out <= 1'b1;
      pos_out <= 1'b1;
      neg_out <= 1'b1;
    end else if (beat_valid) begin
      prev <= next_wire; // R7
      data_out <= next_wire; // R3
      inv_out <= ~use_inv; // R5 R6
      pos_out <= beat_idx[0]; // R3 R4
      neg_out <= ~beat_idx[0]; // R3 R4
    end else begin
      prev <= {W{1'b1}};
      data_out <= {W{1'b1}};
      inv_out <= 1'b1;
      pos_out <= 1'b1;
      neg_out <= 1'b1;
    end
  end

  // ====================================================================
  // receive: two-flop pin synchronisers, third flop only for strobe edges
  logic [W-1:0] d_s1, d_s2;
  logic inv_s1, inv_s2;
  logic pos_s1, pos_s2, pos_s3;
  logic neg_s1, neg_s2, neg_s3;
  logic [1:0] slot;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      d_s1 <= {W{1'b1}};
      d_s2 <= {W{1'b1}};
      inv_s1 <= 1'b1;
      inv_s2 <= 1'b1;
      {pos_s1, pos_s2, pos_s3} <= 3'h7;
      {neg_s1, neg_s2, neg_s3} <= 3'h7;
    end else begin
      d_s1 <= data_pin;
      d_s2 <= d_s1;
      inv_s1 <= inv_pin;
      inv_s2 <= inv_s1;
      {pos_s1, pos_s2, pos_s3} <= {pos_pin, pos_s1, pos_s2};
      {neg_s1, neg_s2, neg_s3} <= {neg_pin, neg_s1, neg_s2};
    end
  end

  // latch on the falling edge of either strobe while data is flagged valid
  wire pos_fall = pos_s3 & ~pos_s2;
  wire neg_fall = neg_s3 & ~neg_s2;
  wire take = listen & ~valid_sync_n & (pos_fall | neg_fall); // R2 R3
  wire [W-1:0] true_word = inv_s2 ? ~d_s2 : d_s2; // R6

  // slot restarts whenever the synchronised valid flag is high, so a torn burst cannot skew
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot <= 2'h0;
      rx_words <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= take && (slot == `QPDBI_BEAT_LAST);
      if (valid_sync_n) begin
        slot <= 2'h0;
      end else if (take) begin
        slot <= slot + 2'h1;
        rx_words[{slot, `QPDBI_GROUP_SHIFT'(0)} +: W] <= true_word; // R3
      end
    end
  end
endmodule

// ==== core/qpdbi_cpu_end.sv ====
// processor end of the quad-pumped data bus, all on the link clock
// assumes the far agent keeps the same pin protocol and that only one end
// is given the data phase at a time (ownership is decided elsewhere)
// What this block does
// R1 - sixty-four data lines shared by every agent
// R2 - driver asserts data valid during transfers
// R3 - four transfers per clock, latched on strobe falls; here one per link clock, four per line
// R4 - each sixteen-line group has own strobe pair
// R5 - inversion flags travel with data, give polarity
// R6 - inverted group flagged; receiver inverts it back
// R7 - invert when over half the lines toggle
// R8 - flag n covers data group n
`timescale 1ns/1ns
`include "qpdbi_consts.svh"
module qpdbi_cpu_end
  import qpdbi_pkg::*;
#(
  parameter int GROUPS = `QPDBI_NUM_GROUPS
) (
  input wire logic link_clk,
  input wire logic rst_n,
  qpdbi_bus_if.cpu_end bus,
  input wire logic [`QPDBI_LINE_W-1:0] tx_line,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [`QPDBI_LINE_W-1:0] rx_line,
  output logic rx_valid
);
  // ====================================================================
  // transmit sequencing
  // pins for a line accepted at link edge k:
  //   k   tx_valid and tx_ready high, line copied to hold
  //   k+1 state drive, beat 0; pins still idle
  //   k+2 beat 0, valid low, positive strobes low, oe up
  //   k+3 beat 1, negative strobes low
  //   k+4 beat 2; tx_ready is high, so a chained line is accepted here
  //   k+5 beat 3, the last beat of this line
  //   k+6 tail, all lines high with oe still up
  //   k+7 oe drops, the pull-ups hold the wires
  // chained, k+4 of one line is k of the next, so
  // beat 0 follows beat 3 with no idle cycle
  // strobes alternate, so each beat brings exactly
  // one falling strobe edge to the far end
  // the pin flops cost one edge of latency, but every
  // pin then comes straight from a flop, glitch free
  qpdbi_state_type state, next_state;
  logic [1:0] beat, next_beat;
  logic [`QPDBI_LINE_W-1:0] hold;
  logic oe;

  // the only moment a line changes hands
  wire accept = tx_valid & tx_ready;
  wire at_last = beat == `QPDBI_BEAT_LAST;
  wire driving = state == qpdbi_drive;
  // word 0 of the line goes out first
  wire [63:0] beat_word = hold[{beat, `QPDBI_BEAT_SHIFT'(0)} +: `QPDBI_DATA_W];

  // a new line may follow the last beat with no gap
  // trade-off: tx_ready is a flop, so it is raised from next_beat
  // one beat early; the accept edge clears it again, so only beat 3
  // or the idle or tail state can take a line
  always_comb begin
    next_state = state;
    next_beat = beat;
    case (state)
      // wait for a line; beats restart at 0
      qpdbi_idle: begin
        if (accept) begin
          next_state = qpdbi_drive;
          next_beat = `QPDBI_BEAT_FIRST;
        end
      end
      // four beats, wrapping to 0 on a chained accept
      qpdbi_drive: begin
        if (!at_last) begin
          next_beat = beat + 2'h1; // R3
        end else if (accept) begin
          next_beat = `QPDBI_BEAT_FIRST;
        end else begin
          next_state = qpdbi_tail;
        end
      end
      // one idle-high cycle; a line may still start here
      qpdbi_tail: begin
        if (accept) begin
          next_state = qpdbi_drive;
          next_beat = `QPDBI_BEAT_FIRST;
        end else begin
          next_state = qpdbi_idle;
        end
      end
      // unused code falls back to idle
      default: begin
        next_state = qpdbi_idle;
      end
    endcase
  end

  // tail cycle drives the lines high before release, so strobes end clean
  // oe trails state by one edge, as the lane pin flops do, so the
  // wires are never let go in the middle of a beat
  // reset releases every pin and holds tx_ready low; it first rises on
  // the edge after reset ends, so a line is taken from the second edge
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= qpdbi_idle;
      beat <= `QPDBI_BEAT_FIRST;
      tx_ready <= 1'b0;
      oe <= 1'b0;
      bus.cpu_valid_o <= 1'b1;
    end else begin
      state <= next_state;
      beat <= next_beat;
      tx_ready <= (next_state != qpdbi_drive) || (next_beat == `QPDBI_BEAT_LAST);
      oe <= state != qpdbi_idle;
      bus.cpu_valid_o <= ~driving; // R2
    end
  end

  // line is captured on acceptance and held through all four beats
  // on a chained accept the lanes sample beat 3 of the old line on the
  // same edge that loads the new one; non-blocking updates keep them apart
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= '0;
    end else if (accept) begin
      hold <= tx_line;
    end
  end

  // one enable for every data-phase pin of this end
  assign bus.cpu_oe = oe;

  // ====================================================================
  // data valid synchroniser, aligned with the lanes' data stages
  // two flops, as for the lane data, so each strobe edge is judged
  // against the valid level of its own beat; a third flop would make
  // the first beat of a burst look invalid
  logic valid_s1, valid_s2;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_s1 <= 1'b1;
      valid_s2 <= 1'b1;
    end else begin
      valid_s1 <= bus.data_valid_flag_n;
      valid_s2 <= valid_s1;
    end
  end

  // ====================================================================
  // four lanes, group g on lines 16g+15..16g with strobe pair g and flag g
  // listen is low while oe is up, so own beats are ignored; the echo of
  // the last own beat still reaches a lane after oe drops, but only as
  // slot 0, and the slot clears once the synchronised valid goes high
  // limitation: nothing arbitrates the bus here; if both ends overlap,
  // this end wins the wires and the far end's line is lost silently
  logic [GROUPS-1:0] lane_done;
  logic [`QPDBI_LINE_W-1:0] rx_asm;

  for (genvar g = 0; g < GROUPS; g++) begin : gl
    logic [4*`QPDBI_GROUP_W-1:0] words;
    qpdbi_lane #(.W(`QPDBI_GROUP_W)) lane (
      .link_clk(link_clk),
      .rst_n(rst_n),
      .beat_valid(driving),
      .beat_idx(beat),
      .tx_group(beat_word[g*16 +: 16]), // R4 R8
      .listen(~oe),
      .valid_sync_n(valid_s2),
      .data_pin(bus.data_n[g*16 +: 16]), // R1 R4
      .pos_pin(bus.positive_data_strobes_n[g]), // R4
      .neg_pin(bus.negative_data_strobes_n[g]), // R4
      .inv_pin(bus.group_inversion_flags_n[g]), // R5 R8
      .data_out(bus.cpu_data_o[g*16 +: 16]),
      .pos_out(bus.cpu_pos_o[g]),
      .neg_out(bus.cpu_neg_o[g]),
      .inv_out(bus.cpu_inv_o[g]), // R8
      .rx_words(words),
      .rx_done(lane_done[g])
    );
    for (genvar b = 0; b < `QPDBI_BEATS; b++) begin : bl
      assign rx_asm[b*64 + g*16 +: 16] = words[b*16 +: 16];
    end
  end

  // ====================================================================
  // line assembly: groups may finish on different cycles under skew
  // a back-to-back burst rewrites slot 0 on the edge that copies the
  // line out; both updates are non-blocking, so the copy is the old line
  // hazard: rx_valid is a one-cycle pulse with no stall, so the user
  // must take the line in that cycle
  logic [GROUPS-1:0] got;
  wire [GROUPS-1:0] next_got = got | lane_done;
  wire line_full = &next_got;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      got <= '0;
      rx_line <= '0;
      rx_valid <= 1'b0;
    end else begin
      got <= line_full ? '0 : next_got;
      rx_valid <= line_full;
      if (line_full) begin
        rx_line <= rx_asm;
      end
    end
  end
endmodule

// ==== core/qpdbi_agent_end.sv ====
// far agent end of the quad-pumped data bus; user side on clk, pins on
// link_clk, lines cross by toggle handshakes with held data
// assumes lines arrive no faster than one per four link clocks
`timescale 1ns/1ns
`include "qpdbi_consts.svh"
module qpdbi_agent_end
  import qpdbi_pkg::*;
#(
  parameter int GROUPS = `QPDBI_NUM_GROUPS
) (
  input wire logic clk,
  input wire logic link_clk,
  input wire logic rst_n,
  qpdbi_bus_if.agent_end bus,
  input wire logic [`QPDBI_LINE_W-1:0] tx_line,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [`QPDBI_LINE_W-1:0] rx_line,
  output logic rx_valid
);
  // ====================================================================
  // user clock side: offer one line at a time, catch delivered lines
  logic req, ack_s1, ack_s2, rt_s1, rt_s2, rt_s3;
  logic [`QPDBI_LINE_W-1:0] xline, rx_hold;
  logic ack, rx_tog;
  wire offer = tx_valid & tx_ready;
  wire next_req = req ^ offer;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {req, ack_s1, ack_s2, tx_ready} <= 4'h0;
      {rt_s1, rt_s2, rt_s3, rx_valid} <= 4'h0;
      xline <= '0;
      rx_line <= '0;
    end else begin
      req <= next_req;
      {ack_s1, ack_s2} <= {ack, ack_s1};
      tx_ready <= next_req == ack_s2;
      {rt_s1, rt_s2, rt_s3} <= {rx_tog, rt_s1, rt_s2};
      rx_valid <= rt_s2 ^ rt_s3;
      if (offer) begin
        xline <= tx_line;
      end
      if (rt_s2 ^ rt_s3) begin
        rx_line <= rx_hold;
      end
    end
  end

  // ====================================================================
  // link side sequencing, same beat pattern as the processor end
  qpdbi_state_type state, next_state;
  logic [1:0] beat, next_beat;
  logic [`QPDBI_LINE_W-1:0] hold;
  logic oe, req_s1, req_s2, valid_s1, valid_s2;
  wire pend = req_s2 ^ ack;
  wire at_last = beat == `QPDBI_BEAT_LAST;
  wire driving = state == qpdbi_drive;
  wire take = pend & (!driving | at_last);
  wire [63:0] beat_word = hold[{beat, `QPDBI_BEAT_SHIFT'(0)} +: `QPDBI_DATA_W];

  always_comb begin
    next_state = state;
    next_beat = beat;
    case (state)
      qpdbi_idle, qpdbi_tail: begin
        next_state = take ? qpdbi_drive : qpdbi_idle;
        next_beat = `QPDBI_BEAT_FIRST;
      end
      qpdbi_drive: begin
        next_beat = beat + 2'h1; // R3
        if (at_last && !take) begin
          next_state = qpdbi_tail;
        end
      end
      default: begin
        next_state = qpdbi_idle;
      end
    endcase
  end

  // held xline is stable while the request toggle is unanswered
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= qpdbi_idle;
      beat <= `QPDBI_BEAT_FIRST;
      {oe, ack, req_s1, req_s2} <= 4'h0;
      {valid_s1, valid_s2} <= 2'h3;
      bus.agt_valid_o <= 1'b1;
      hold <= '0;
    end else begin
      state <= next_state;
      beat <= next_beat;
      oe <= state != qpdbi_idle;
      {req_s1, req_s2} <= {req, req_s1};
      {valid_s1, valid_s2} <= {bus.data_valid_flag_n, valid_s1};
      bus.agt_valid_o <= ~driving; // R2
      if (take) begin
        hold <= xline;
        ack <= ~ack;
      end
    end
  end

  assign bus.agt_oe = oe;

  // ====================================================================
  // lanes and receive assembly
  logic [GROUPS-1:0] lane_done, got;
  logic [`QPDBI_LINE_W-1:0] rx_asm;
  wire [GROUPS-1:0] next_got = got | lane_done;
  wire line_full = &next_got;

  for (genvar g = 0; g < GROUPS; g++) begin : gl
    logic [4*`QPDBI_GROUP_W-1:0] words;
    qpdbi_lane #(.W(`QPDBI_GROUP_W)) lane (
      .link_clk(link_clk),
      .rst_n(rst_n),
      .beat_valid(driving),
      .beat_idx(beat),
      .tx_group(beat_word[g*16 +: 16]), // R8
      .listen(~oe),
      .valid_sync_n(valid_s2),
      .data_pin(bus.data_n[g*16 +: 16]), // R1 R4
      .pos_pin(bus.positive_data_strobes_n[g]),
      .neg_pin(bus.negative_data_strobes_n[g]),
      .inv_pin(bus.group_inversion_flags_n[g]), // R5
      .data_out(bus.agt_data_o[g*16 +: 16]),
      .pos_out(bus.agt_pos_o[g]),
      .neg_out(bus.agt_neg_o[g]),
      .inv_out(bus.agt_inv_o[g]), // R8
      .rx_words(words),
      .rx_done(lane_done[g])
    );
    for (genvar b = 0; b < `QPDBI_BEATS; b++) begin : bl
      assign rx_asm[b*64 + g*16 +: 16] = words[b*16 +: 16];
    end
  end

  // completed line is parked in rx_hold and announced by a toggle
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      got <= '0;
      rx_tog <= 1'b0;
      rx_hold <= '0;
    end else begin
      got <= line_full ? '0 : next_got;
      if (line_full) begin
        rx_hold <= rx_asm;
        rx_tog <= ~rx_tog;
      end
    end
  end
endmodule

// ==== tb/qpdbi_bus_asserts.sv ====
// checker for the wires of the quad-pumped inverted data bus
// assumes it is instantiated beside the interface, all on link_clk
`timescale 1ns/1ns
module qpdbi_bus_asserts (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic [63:0] data_n,
  input wire logic data_valid_flag_n,
  input wire logic [3:0] positive_data_strobes_n,
  input wire logic [3:0] negative_data_strobes_n,
  input wire logic [3:0] group_inversion_flags_n
);
  // ====================================================================
  // helper logic
  wire logic [3:0] pos = positive_data_strobes_n;
  wire logic [3:0] neg = negative_data_strobes_n;
  wire logic beat = !data_valid_flag_n && (pos == 4'h0 || neg == 4'h0);
  logic [63:0] prev;
  logic [7:0] low_cnt;
  wire logic inv_bad = bad_choice(data_n, prev, group_inversion_flags_n);

  // a ninth toggle is never sent plain; exactly eight must stay plain
  function automatic logic bad_choice(input logic [63:0] w, p, input logic [3:0] f);
    int t;
    bad_choice = 1'b0;
    for (int g = 0; g < 4; g++) begin
      t = $countones(w[16*g +: 16] ^ p[16*g +: 16]);
      if (f[g] ? (t > 8) : (t >= 8)) bad_choice = 1'b1;
    end
  endfunction

  // last wire beat, back to all ones outside bursts
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) prev <= 64'hFFFF_FFFF_FFFF_FFFF;
    else if (beat) prev <= data_n;
    else if (data_valid_flag_n) prev <= 64'hFFFF_FFFF_FFFF_FFFF;
  end

  // length of the current run of valid beats
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 8'h00;
    else low_cnt <= data_valid_flag_n ? 8'h00 : low_cnt + 8'h01;
  end

  // ====================================================================
  // assertions
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);

  a_valid_with_strobe: assert property ((pos != 4'hF || neg != 4'hF) |-> !data_valid_flag_n)
    else $error("strobe active without data valid");
  a_pair_moves_together: assert property ((pos == 4'h0 || pos == 4'hF) && (neg == 4'h0 || neg == 4'hF))
    else $error("strobe groups out of step");
  a_strobe_exclusive: assert property (!(pos == 4'h0 && neg == 4'h0))
    else $error("both strobes active together");
  a_neg_follows_pos: assert property (pos == 4'h0 |=> neg == 4'h0)
    else $error("negative strobe did not follow positive");
  a_four_beats: assert property ($fell(data_valid_flag_n) |-> pos == 4'h0 ##1 neg == 4'h0
    ##1 pos == 4'h0 ##1 neg == 4'h0)
    else $error("burst does not strobe four beats");
  a_beat_count: assert property ($rose(data_valid_flag_n) |-> low_cnt[1:0] == 2'h0 && low_cnt != 8'h00)
    else $error("valid run not a multiple of four beats");
  a_inversion_choice: assert property (beat |-> !inv_bad)
    else $error("group inversion decision wrong");
  a_idle_quiet: assert property (data_valid_flag_n |-> group_inversion_flags_n == 4'hF && data_n == 64'hFFFF_FFFF_FFFF_FFFF)
    else $error("flags or data active outside a transfer");
endmodule

// ==== tb/quad_pumped_data_bus_inversion_tb.sv ====
// self-checking bench: processor end and agent end joined by the bus interface
// assumes the design files of core/ and the consts header on the include path
`timescale 1ns/1ns
`include "qpdbi_consts.svh"
module quad_pumped_data_bus_inversion_tb;
  typedef logic [`QPDBI_LINE_W-1:0] qpdbi_line_type;
  localparam int LIMIT = 12000;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  qpdbi_line_type c_tx_line = '0;
  qpdbi_line_type a_tx_line = '0;
  qpdbi_line_type c_rx_line, a_rx_line, wacc, l0;
  logic c_tx_valid = 1'b0;
  logic a_tx_valid = 1'b0;
  logic c_tx_ready, a_tx_ready, c_rx_valid, a_rx_valid;
  qpdbi_line_type to_agt[$], to_cpu[$], on_wire[$];
  logic [31:0] lfsr = 32'h0001_5800;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int wbeat = 0;

  // ====================================================================
  // clocks: link clock phase unrelated to the user clock
  always #25 clk = ~clk;
  always begin
    #63 link_clk = ~link_clk;
    #62 link_clk = ~link_clk;
  end

  // ====================================================================
  // design and checker
  qpdbi_bus_if bus ();
  qpdbi_cpu_end qpdbi_cpu_end_inst (.link_clk(link_clk), .rst_n(rst_n), .bus(bus),
    .tx_line(c_tx_line), .tx_valid(c_tx_valid), .tx_ready(c_tx_ready),
    .rx_line(c_rx_line), .rx_valid(c_rx_valid));
  qpdbi_agent_end qpdbi_agent_end_inst (.clk(clk), .link_clk(link_clk), .rst_n(rst_n),
    .bus(bus), .tx_line(a_tx_line), .tx_valid(a_tx_valid), .tx_ready(a_tx_ready),
    .rx_line(a_rx_line), .rx_valid(a_rx_valid));
  qpdbi_bus_asserts qpdbi_bus_asserts_inst (.link_clk(link_clk), .rst_n(rst_n),
    .data_n(bus.data_n), .data_valid_flag_n(bus.data_valid_flag_n),
    .positive_data_strobes_n(bus.positive_data_strobes_n),
    .negative_data_strobes_n(bus.negative_data_strobes_n),
    .group_inversion_flags_n(bus.group_inversion_flags_n));

  // ====================================================================
  // shared tasks
  task automatic check(input qpdbi_line_type got, input qpdbi_line_type exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // an unexpected line meets an empty queue and compares against unknown
  task automatic take(input qpdbi_line_type got, ref qpdbi_line_type q[$]);
    check(got, q.size() != 0 ? q.pop_front() : 'x);
  endtask

  function automatic qpdbi_line_type rand_line();
    for (int i = 0; i < 8; i++) begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      rand_line[32*i +: 32] = lfsr;
    end
  endfunction

  // valid stays up after acceptance so the next call chains a line
  task automatic cpu_send(input qpdbi_line_type l);
    #2;
    c_tx_line = l;
    c_tx_valid = 1'b1;
    do @(posedge link_clk); while (c_tx_ready !== 1'b1);
    to_agt.push_back(l);
    on_wire.push_back(l);
  endtask

  task automatic agt_send(input qpdbi_line_type l);
    #2;
    a_tx_line = l;
    a_tx_valid = 1'b1;
    do @(posedge clk); while (a_tx_ready !== 1'b1);
    to_cpu.push_back(l);
    on_wire.push_back(l);
  endtask

  // waits for every expected line, then a quiet spell for stray pulses
  task automatic drain;
    int left;
    #2;
    c_tx_valid = 1'b0;
    a_tx_valid = 1'b0;
    for (int i = 0; i < 400 && to_agt.size() + to_cpu.size() + on_wire.size() != 0; i++)
      @(posedge link_clk);
    repeat (10) @(posedge link_clk);
    left = to_agt.size() + to_cpu.size() + on_wire.size();
    check(qpdbi_line_type'(left), '0);
  endtask

  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ====================================================================
  // monitors: user-side deliveries and the wire decoded by polarity
  always @(posedge clk) if (a_rx_valid === 1'b1) take(a_rx_line, to_agt);
  always @(posedge link_clk) if (c_rx_valid === 1'b1) take(c_rx_line, to_cpu);
  always @(posedge link_clk) begin
    if (bus.data_valid_flag_n !== 1'b0) wbeat = 0;
    else if (bus.positive_data_strobes_n === 4'h0 || bus.negative_data_strobes_n === 4'h0) begin
      for (int g = 0; g < 4; g++)
        wacc[64*wbeat + 16*g +: 16] = bus.group_inversion_flags_n[g] ?
          ~bus.data_n[16*g +: 16] : bus.data_n[16*g +: 16];
      wbeat++;
      if (wbeat == 4) begin
        wbeat = 0;
        take(wacc, on_wire);
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      end_of_test;
    end
  end

  // ====================================================================
  // main sequence
  initial begin
    l0 = {64'h1234_5678_9ABC_DEF0, 64'h0000_FEFF_FE00_FF00, 64'h0000_FFFF_FE00_FF00,
      64'hFFFF_0000_01FF_00FF};
    repeat (4) @(posedge link_clk);
    #2 rst_n = 1'b1;
    repeat (2) @(posedge link_clk);
    // eight and nine toggles per group, chained with no gap
    cpu_send(l0);
    cpu_send(~l0);
    cpu_send(l0);
    drain;
    $display("test 1 done: processor end boundary lines");
    @(posedge clk);
    agt_send(l0);
    agt_send(~l0);
    drain;
    $display("test 2 done: agent end boundary lines");
    for (int i = 0; i < 6; i++) begin
      cpu_send(rand_line());
      cpu_send(rand_line());
      drain;
      @(posedge clk);
      agt_send(rand_line());
      agt_send(rand_line());
      drain;
    end
    $display("test 3 done: random lines both ways");
    end_of_test;
  end
endmodule
